// *** verilog/dma_end_pkg.sv ***
/*
 * Shared constants and types for the DMA end-interrupt and halt block.
 * Assumes a 32-bit AXI4-Lite register bus and four sub-channels.
 */
`default_nettype none

package dma_end_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int unsigned NUM_SUB = 4;
	localparam int unsigned ADDR_W = 8;
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_MAR = 5'h04;
	localparam logic [4:0] OFS_IO_ADDRESS_REG = 5'h08;
	localparam logic [4:0] OFS_CNT = 5'h0C;
	localparam logic [4:0] OFS_BLK_INIT = 5'h10;
	localparam logic [4:0] OFS_BLK_CNT = 5'h14;
	localparam logic [7:0] OFS_CONFIG = 8'h80;
	localparam logic [7:0] OFS_STATUS = 8'h84;
	localparam int unsigned GLOBAL_BIT = 7;
	localparam int unsigned SUB_MSB = 6;
	localparam int unsigned SUB_LSB = 5;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int unsigned CTRL_TE_BIT = 0;
	localparam int unsigned CTRL_ME_BIT = 1;
	localparam int unsigned CTRL_IE_BIT = 2;
	localparam int unsigned CTRL_BLK_BIT = 3;
	localparam int unsigned CTRL_WORD_BIT = 4;
	localparam int unsigned CFG_FULL0_BIT = 0;
	localparam int unsigned CFG_FULL1_BIT = 1;
	localparam int unsigned CFG_MB16_BIT = 2;
	localparam int unsigned STAT_HALT_LSB = 4;

	// ------------------------------------------------------------
	// Address forming and step sizes
	// ------------------------------------------------------------
	localparam logic [23:0] IO_BASE_1M = 24'h0FFF00;
	localparam logic [23:0] IO_BASE_16M = 24'hFFFF00;
	localparam logic [23:0] MAR_1M_MASK = 24'h0FFFFF;
	localparam logic [23:0] STEP_BYTE = 24'h000001;
	localparam logic [23:0] STEP_WORD = 24'h000002;
	localparam logic [15:0] CNT_LAST = 16'h0001;
	localparam logic [7:0] BLK_LAST = 8'h01;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		SEQ_IDLE,
		SEQ_TOP,
		SEQ_E,
		SEQ_GAP,
		SEQ_H,
		SEQ_L
	} mar_seq_type;

	typedef struct packed {
		logic te;
		logic me;
		logic ie;
		logic blk_mode;
		logic word;
		logic [23:0] memory_address_reg;
		logic [7:0] io_address_reg;
		logic [15:0] cnt;
		logic [7:0] blk_init;
		logic [7:0] blk_cnt;
		logic pending;
	} chan_state_type;

	typedef struct packed {
		logic valid;
		logic [1:0] sub;
		logic word;
		logic [23:0] mem_addr;
		logic [23:0] io_addr;
	} xfer_type;

endpackage : dma_end_pkg

`default_nettype wire

// *** verilog/dma_sub_channel.sv ***
/*
 * One DMA sub-channel: control bits, address registers, counters and the
 * activation, halt and transfer-step behaviour.
 * Gates nmi_i to full address mode itself; assumes the parent issues step_i
 * one cycle after arbitration.
 */
`default_nettype none

module dma_sub_channel
	import dma_end_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic init_i,
	// Mode
	input wire logic full_i,
	input wire logic sub_b_i,
	// Register writes
	input wire logic wr_ctrl_i,
	input wire logic wr_io_address_reg_i,
	input wire logic wr_cnt_i,
	input wire logic wr_blk_i,
	input wire logic [2:0] wr_mar_i,
	input wire logic [31:0] wdata_i,
	// Events
	input wire logic nmi_i,
	input wire logic act_i,
	input wire logic step_i,
	// State
	output chan_state_type st_o,
	output logic run_o,
	output logic fwd_o,
	output logic clr_o
);

	chan_state_type s_r;
	chan_state_type s_nxt;
	logic halted;

	assign run_o = full_i ? (~sub_b_i & s_r.te & s_r.me) : s_r.te;
	assign halted = full_i & ~sub_b_i & s_r.te & ~s_r.me;
	assign st_o = s_r;
	// With the channel stopped the source reaches the CPU again.
	assign fwd_o = act_i & ~s_r.te;

	always_comb
	begin
		s_nxt = s_r;
		clr_o = 1'b0;
		if (wr_ctrl_i)
		begin
			s_nxt.te = wdata_i[CTRL_TE_BIT];
			s_nxt.me = wdata_i[CTRL_ME_BIT];
			s_nxt.ie = wdata_i[CTRL_IE_BIT];
			s_nxt.blk_mode = wdata_i[CTRL_BLK_BIT];
			s_nxt.word = wdata_i[CTRL_WORD_BIT];
		end
		if (wr_io_address_reg_i)
			s_nxt.io_address_reg = wdata_i[7:0];
		if (wr_cnt_i)
			s_nxt.cnt = wdata_i[15:0];
		if (wr_blk_i)
		begin
			s_nxt.blk_init = wdata_i[7:0];
			s_nxt.blk_cnt = wdata_i[7:0];
		end
		for (int k = 0; k < 3; k++)
			if (wr_mar_i[k])
				s_nxt.memory_address_reg[k*8 +: 8] = wdata_i[k*8 +: 8];
		// A halted channel drops activations instead of queueing them.
		if (act_i && run_o && !halted)
			s_nxt.pending = 1'b1;
		// A step granted to a channel that has since halted is a dead
		// cycle and must not disturb the address or the counters.
		if (step_i && run_o && s_r.pending)
		begin
			s_nxt.memory_address_reg = s_r.memory_address_reg + (s_r.word ? STEP_WORD : STEP_BYTE);
			s_nxt.cnt = s_r.cnt - CNT_LAST;
			if (s_r.blk_mode)
			begin
				if (s_r.blk_cnt == BLK_LAST)
				begin
					s_nxt.blk_cnt = s_r.blk_init;
					s_nxt.pending = 1'b0;
				end
				else
					s_nxt.blk_cnt = s_r.blk_cnt - BLK_LAST;
			end
			else
				s_nxt.pending = 1'b0;
			if (s_r.cnt == CNT_LAST)
			begin
				s_nxt.te = 1'b0;
				s_nxt.pending = 1'b0;
			end
		end
		// The current unit above completes first; then the stop.
		if (nmi_i && full_i && !sub_b_i)
		begin
			s_nxt.me = 1'b0;
			if (s_nxt.blk_mode && s_nxt.blk_cnt != s_nxt.blk_init)
			begin
				s_nxt.pending = 1'b0;
				clr_o = 1'b1;
			end
		end
		if (init_i)
			s_nxt = '0;
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

endmodule : dma_sub_channel

`default_nettype wire

// *** verilog/dma_end_irq_ctrl.sv ***
/*
 * DMA end-interrupt and halt control: AXI4-Lite register slave, four
 * sub-channels, fixed-priority transfer grant and end-interrupt lines.
 * Assumes activation and NMI inputs are synchronous one-cycle pulses and
 * that an external bus engine consumes the xfer_o descriptor.
 */
`default_nettype none

// Overview of operation
// - Only end-of-transfer interrupts exist, one per sub-channel 0A, 0B, 1A, 1B.
// - Each sub-channel drives its own request line, gated by its enable bit.
// - A request is raised while transfer enable is 0 and interrupt enable 1.
// - Priority: channel 0 over channel 1, sub-channel A over B.
// - In full address mode the B end interrupt is never raised.
// - The master enable bit plays no part in end interrupts.
// - Registers refuse access during a transfer cycle; never self-targeted.
// - A memory address write runs as four byte steps, releasable mid-way.
// - In full address mode, sub-channel A with transfer enabled but master disabled: halt, drop and never forward activations.
// - Clearing transfer enable while halted ends it and frees CPU interrupts.
// - NMI in full address block mode finishes the unit, clears master enable, halts.
// - A mid-block NMI halt clears the activating flag and drops the request.
// - After master enable returns, the next request resumes the block.
// - I/O addresses stay within the top 256-byte page of the space.
// - In 1-Mbyte mode memory address bits 23 to 20 are ignored.
// - A dead cycle after abort or NMI leaves address and counter unchanged.
// - NMI in full address mode clears master enable after the current unit.
// - Reset or software standby initialises and halts everything.
module dma_end_irq_ctrl
	import dma_end_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// AXI4-Lite write address and data
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// System events
	input wire logic nmi_i,
	input wire logic standby_i,
	input wire logic [NUM_SUB-1:0] act_i,
	// Activating source control
	output logic [NUM_SUB-1:0] act_fwd_o,
	output logic [NUM_SUB-1:0] act_clr_o,
	// End interrupts, index 0 = 0A, 1 = 0B, 2 = 1A, 3 = 1B
	output logic [NUM_SUB-1:0] end_irq_o,
	// Transfer descriptor
	output xfer_type xfer_o
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic aw_hold;
		logic [ADDR_W-1:0] aw_addr;
		logic w_hold;
		logic [31:0] wdata;
		mar_seq_type seq;
		logic [1:0] seq_sub;
		logic full0;
		logic full1;
		logic mb16;
		xfer_type xfer;
		logic [NUM_SUB-1:0] fwd;
		logic [NUM_SUB-1:0] clr;
		logic [NUM_SUB-1:0] irq;
	} top_state_type;

	top_state_type s_r;
	top_state_type s_nxt;
	chan_state_type [NUM_SUB-1:0] ch;
	logic [NUM_SUB-1:0] run;
	logic [NUM_SUB-1:0] fwd;
	logic [NUM_SUB-1:0] clr;
	logic [NUM_SUB-1:0] full_sub;
	logic [NUM_SUB-1:0] wr_ctrl;
	logic [NUM_SUB-1:0] wr_io_address_reg;
	logic [NUM_SUB-1:0] wr_cnt;
	logic [NUM_SUB-1:0] wr_blk;
	logic [NUM_SUB-1:0][2:0] wr_mar;
	logic [NUM_SUB-1:0] step;
	logic [NUM_SUB-1:0] req;
	logic [31:0] reg_wdata;

	// ------------------------------------------------------------
	// Address decoding
	// ------------------------------------------------------------
	function automatic logic is_sub(input logic [ADDR_W-1:0] a);
		is_sub = ~a[GLOBAL_BIT];
	endfunction : is_sub

	function automatic logic [1:0] sub_of(input logic [ADDR_W-1:0] a);
		sub_of = a[SUB_MSB:SUB_LSB];
	endfunction : sub_of

	function automatic logic [4:0] ofs_of(input logic [ADDR_W-1:0] a);
		ofs_of = a[4:0];
	endfunction : ofs_of

	function automatic logic [23:0] mem_addr(input logic [23:0] memory_address_reg,
		input logic mb16);
		mem_addr = mb16 ? memory_address_reg : (memory_address_reg & MAR_1M_MASK);
	endfunction : mem_addr

	function automatic logic [23:0] io_addr(input logic [7:0] io_address_reg,
		input logic mb16);
		io_addr = (mb16 ? IO_BASE_16M : IO_BASE_1M) | {16'h0000, io_address_reg};
	endfunction : io_addr

	// ------------------------------------------------------------
	// Sub-channels
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_SUB; g++)
		begin : gen_sub
			assign full_sub[g] = (g < 2) ? s_r.full0 : s_r.full1;
			assign step[g] = s_r.xfer.valid && (s_r.xfer.sub == 2'(g));
			assign req[g] = run[g] & ch[g].pending;
			dma_sub_channel u_sub (
				.clk_i(clk_i),
				.rst_b_i(rst_b_i),
				.init_i(standby_i),
				.full_i(full_sub[g]),
				.sub_b_i(g % 2 == 1),
				.wr_ctrl_i(wr_ctrl[g]),
				.wr_io_address_reg_i(wr_io_address_reg[g]),
				.wr_cnt_i(wr_cnt[g]),
				.wr_blk_i(wr_blk[g]),
				.wr_mar_i(wr_mar[g]),
				.wdata_i(reg_wdata),
				.nmi_i(nmi_i),
				.act_i(act_i[g]),
				.step_i(step[g]),
				.st_o(ch[g]),
				.run_o(run[g]),
				.fwd_o(fwd[g]),
				.clr_o(clr[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		logic [1:0] sub;
		logic [4:0] ofs;
		logic [1:0] rsub;
		logic granted;
		sub = sub_of(s_r.aw_addr);
		ofs = ofs_of(s_r.aw_addr);
		rsub = sub_of(s_axi_araddr);
		granted = 1'b0;
		s_nxt = s_r;
		reg_wdata = s_r.wdata;
		wr_ctrl = '0;
		wr_io_address_reg = '0;
		wr_cnt = '0;
		wr_blk = '0;
		wr_mar = '0;

		if (s_axi_awvalid && s_r.awready)
		begin
			s_nxt.aw_hold = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_r.wready)
		begin
			s_nxt.w_hold = 1'b1;
			s_nxt.wdata = s_axi_wdata;
		end
		if (s_axi_bvalid && s_axi_bready)
			s_nxt.bvalid = 1'b0;
		if (s_axi_rvalid && s_axi_rready)
			s_nxt.rvalid = 1'b0;

		// Register writes wait out any transfer cycle in flight.
		if (s_r.aw_hold && s_r.w_hold && s_r.seq == SEQ_IDLE
			&& !s_r.bvalid && !s_r.xfer.valid)
		begin
			s_nxt.aw_hold = 1'b0;
			s_nxt.w_hold = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = RESP_OKAY;
			if (is_sub(s_r.aw_addr))
			begin
				if (ofs == OFS_CTRL)
					wr_ctrl[sub] = 1'b1;
				else if (ofs == OFS_IO_ADDRESS_REG)
					wr_io_address_reg[sub] = 1'b1;
				else if (ofs == OFS_CNT)
					wr_cnt[sub] = 1'b1;
				else if (ofs == OFS_BLK_INIT)
					wr_blk[sub] = 1'b1;
				else if (ofs == OFS_MAR)
				begin
					s_nxt.bvalid = 1'b0;
					s_nxt.seq = SEQ_TOP;
					s_nxt.seq_sub = sub;
				end
				else
					s_nxt.bresp = RESP_SLVERR;
			end
			else if (s_r.aw_addr == OFS_CONFIG)
			begin
				s_nxt.full0 = s_r.wdata[CFG_FULL0_BIT];
				s_nxt.full1 = s_r.wdata[CFG_FULL1_BIT];
				s_nxt.mb16 = s_r.wdata[CFG_MB16_BIT];
			end
			else if (s_r.aw_addr != OFS_STATUS)
				s_nxt.bresp = RESP_SLVERR;
		end

		// Four byte steps: the reserved top byte, then the upper, high
		// and low bytes, with the bus offered to the engine in between
		// the second and third step.
		case (s_r.seq)
			SEQ_TOP:
				s_nxt.seq = SEQ_E;
			SEQ_E:
			begin
				wr_mar[s_r.seq_sub][2] = 1'b1;
				s_nxt.seq = SEQ_GAP;
			end
			SEQ_GAP:
				if (!s_r.xfer.valid && req == '0)
					s_nxt.seq = SEQ_H;
			SEQ_H:
			begin
				wr_mar[s_r.seq_sub][1] = 1'b1;
				s_nxt.seq = SEQ_L;
			end
			SEQ_L:
			begin
				wr_mar[s_r.seq_sub][0] = 1'b1;
				s_nxt.seq = SEQ_IDLE;
				s_nxt.bvalid = 1'b1;
				s_nxt.bresp = RESP_OKAY;
			end
			default:
			begin
			end
		endcase

		// One transfer unit at a time, lowest index first.
		s_nxt.xfer.valid = 1'b0;
		if (!s_r.xfer.valid && (s_r.seq == SEQ_IDLE || s_r.seq == SEQ_GAP))
		begin
			for (int k = 0; k < NUM_SUB; k++)
				if (req[k] && !granted && !step[k])
				begin
					granted = 1'b1;
					s_nxt.xfer.valid = 1'b1;
					s_nxt.xfer.sub = 2'(k);
					s_nxt.xfer.word = ch[k].word;
					s_nxt.xfer.mem_addr = mem_addr(ch[k].memory_address_reg, s_r.mb16);
					s_nxt.xfer.io_addr = io_addr(ch[k].io_address_reg, s_r.mb16);
				end
		end

		// Reads are also held off during a transfer cycle.
		s_nxt.arready = !s_nxt.rvalid && !s_nxt.xfer.valid;
		if (s_axi_arvalid && s_r.arready)
		begin
			s_nxt.arready = 1'b0;
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = RESP_OKAY;
			s_nxt.rdata = '0;
			if (is_sub(s_axi_araddr))
			begin
				if (ofs_of(s_axi_araddr) == OFS_CTRL)
				begin
					s_nxt.rdata[CTRL_TE_BIT] = ch[rsub].te;
					s_nxt.rdata[CTRL_ME_BIT] = ch[rsub].me;
					s_nxt.rdata[CTRL_IE_BIT] = ch[rsub].ie;
					s_nxt.rdata[CTRL_BLK_BIT] = ch[rsub].blk_mode;
					s_nxt.rdata[CTRL_WORD_BIT] = ch[rsub].word;
				end
				else if (ofs_of(s_axi_araddr) == OFS_MAR)
					s_nxt.rdata[23:0] = ch[rsub].memory_address_reg;
				else if (ofs_of(s_axi_araddr) == OFS_IO_ADDRESS_REG)
					s_nxt.rdata[7:0] = ch[rsub].io_address_reg;
				else if (ofs_of(s_axi_araddr) == OFS_CNT)
					s_nxt.rdata[15:0] = ch[rsub].cnt;
				else if (ofs_of(s_axi_araddr) == OFS_BLK_INIT)
					s_nxt.rdata[7:0] = ch[rsub].blk_init;
				else if (ofs_of(s_axi_araddr) == OFS_BLK_CNT)
					s_nxt.rdata[7:0] = ch[rsub].blk_cnt;
				else
					s_nxt.rresp = RESP_SLVERR;
			end
			else if (s_axi_araddr == OFS_CONFIG)
			begin
				s_nxt.rdata[CFG_FULL0_BIT] = s_r.full0;
				s_nxt.rdata[CFG_FULL1_BIT] = s_r.full1;
				s_nxt.rdata[CFG_MB16_BIT] = s_r.mb16;
			end
			else if (s_axi_araddr == OFS_STATUS)
			begin
				s_nxt.rdata[NUM_SUB-1:0] = s_r.irq;
				for (int k = 0; k < NUM_SUB; k++)
					s_nxt.rdata[STAT_HALT_LSB + k] = ch[k].te & ~run[k];
			end
			else
				s_nxt.rresp = RESP_SLVERR;
		end

		s_nxt.awready = !s_nxt.aw_hold && !s_nxt.bvalid
			&& s_nxt.seq == SEQ_IDLE;
		s_nxt.wready = !s_nxt.w_hold && !s_nxt.bvalid
			&& s_nxt.seq == SEQ_IDLE;
		s_nxt.fwd = fwd;
		s_nxt.clr = clr;

		// Level requests from the current bits only; master enable is
		// deliberately left out.
		for (int k = 0; k < NUM_SUB; k++)
			s_nxt.irq[k] = ~ch[k].te & ch[k].ie;
		if (s_r.full0)
			s_nxt.irq[1] = 1'b0;
		if (s_r.full1)
			s_nxt.irq[3] = 1'b0;

		if (standby_i)
		begin
			s_nxt = '0;
			s_nxt.awready = 1'b1;
			s_nxt.wready = 1'b1;
			s_nxt.arready = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign s_axi_awready = s_r.awready;
	assign s_axi_wready = s_r.wready;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_arready = s_r.arready;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rresp = s_r.rresp;
	assign s_axi_rdata = s_r.rdata;
	assign act_fwd_o = s_r.fwd;
	assign act_clr_o = s_r.clr;
	assign end_irq_o = s_r.irq;
	assign xfer_o = s_r.xfer;

endmodule : dma_end_irq_ctrl

`default_nettype wire

// *** tb/dma_end_irq_ctrl_properties.sv ***
/*
 * Port-level checker for the DMA end-interrupt and halt block.
 * Assumes it is bound to dma_end_irq_ctrl and sees only its ports.
 */
`default_nettype none

module dma_end_irq_ctrl_checker
	import dma_end_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Events
	input wire logic nmi_i,
	input wire logic standby_i,
	input wire logic [NUM_SUB-1:0] act_i,
	input wire logic s_axi_bvalid,
	// Outputs watched
	input wire logic [NUM_SUB-1:0] act_fwd_o,
	input wire logic [NUM_SUB-1:0] act_clr_o,
	input wire logic [NUM_SUB-1:0] end_irq_o,
	input wire xfer_type xfer_o
);
	logic xv;

	assign xv = xfer_o.valid;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);

	// ------------------------------------------------------------
	// Sequences
	// ------------------------------------------------------------
	sequence s_standby_seen;
		standby_i ##1 1'b1;
	endsequence

	sequence s_clr_seen;
		(act_clr_o != 4'h0) ##1 1'b1;
	endsequence

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	chk_fwd_cause: assert property (
		(act_fwd_o & ~$past(act_i)) == 4'h0)
		else $error("forwarded activation without a source pulse");
	chk_fwd_excl: assert property (
		xv |-> !act_fwd_o[xfer_o.sub])
		else $error("activation forwarded on a transferring channel");
	chk_clr_cause: assert property (
		(act_clr_o != 4'h0) |-> ($past(nmi_i) || $past(nmi_i, 2)))
		else $error("activating flag cleared without an NMI");
	chk_clr_pulse: assert property (
		s_clr_seen |-> act_clr_o == 4'h0)
		else $error("flag clear pulse longer than one cycle");
	chk_io_range: assert property (
		xv |-> (xfer_o.io_addr[23:8] == 16'hFFFF
		|| xfer_o.io_addr[23:8] == 16'h0FFF))
		else $error("I/O address outside the top page");
	chk_mar_1m: assert property (
		xv && xfer_o.io_addr[23:20] == 4'h0
		|-> xfer_o.mem_addr[23:20] == 4'h0)
		else $error("memory address top bits used in 1-Mbyte mode");
	chk_standby_init: assert property (
		s_standby_seen |-> end_irq_o == 4'h0 && !xv && act_fwd_o == 4'h0)
		else $error("standby did not initialise the block");
	chk_irq_cause: assert property (
		$changed(end_irq_o) |-> s_axi_bvalid || $past(s_axi_bvalid)
		|| $past(s_axi_bvalid, 2) || $past(xv, 2) || $past(xv, 3)
		|| $past(xv, 4) || $past(xv, 5) || $past(standby_i))
		else $error("end interrupt changed without a cause");

endmodule : dma_end_irq_ctrl_checker

bind dma_end_irq_ctrl dma_end_irq_ctrl_checker u_chk (
	.clk_i(clk_i),
	.rst_b_i(rst_b_i),
	.nmi_i(nmi_i),
	.standby_i(standby_i),
	.act_i(act_i),
	.s_axi_bvalid(s_axi_bvalid),
	.act_fwd_o(act_fwd_o),
	.act_clr_o(act_clr_o),
	.end_irq_o(end_irq_o),
	.xfer_o(xfer_o)
);

`default_nettype wire

// *** tb/dma_irq_partner.sv ***
/*
 * Model of the activating source and the CPU-side interrupt controller.
 * Assumes the bench fires sources, also while transfer enable is clear.
 */
`default_nettype none

module dma_irq_partner
	import dma_end_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// From bench and block
	input wire logic [NUM_SUB-1:0] fire_i,
	input wire logic [NUM_SUB-1:0] fwd_i,
	input wire logic [NUM_SUB-1:0] clr_i,
	// To block and bench
	output logic [NUM_SUB-1:0] act_o,
	output logic [NUM_SUB-1:0] flag_o,
	output logic [7:0] fwd_cnt_o
);
	// Sources fire only when told, whether or not the channel is enabled.
	assign act_o = fire_i;

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			flag_o <= 4'h0;
			fwd_cnt_o <= 8'h00;
		end
		else
		begin
			flag_o <= (flag_o & ~clr_i) | fire_i;
			fwd_cnt_o <= fwd_cnt_o + 8'($countones(fwd_i));
		end
	end
endmodule : dma_irq_partner

`default_nettype wire

// *** tb/dma_end_irq_and_halt_control_test.sv ***
/*
 * Self-checking bench for the DMA end-interrupt and halt block.
 * Assumes the partner model in dma_irq_partner and a 200 MHz clock.
 */
`default_nettype none

module dma_end_irq_and_halt_control_test;
	import dma_end_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic nmi_i = 1'b0, standby_i = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic [3:0] fire = 4'h0, act, fwd, clr, irq, flag;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rsp;
	logic [7:0] fwd_cnt, cnt0;
	xfer_type xfer;
	xfer_type q[$];
	int error_cnt = 0, n_checks = 0;

	always #2.5 clk_i = ~clk_i;
	always @(posedge clk_i) if (xfer.valid) q.push_back(xfer);

	dma_end_irq_ctrl dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .nmi_i(nmi_i), .standby_i(standby_i),
		.act_i(act), .act_fwd_o(fwd), .act_clr_o(clr), .end_irq_o(irq),
		.xfer_o(xfer));

	dma_irq_partner u_partner (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.fire_i(fire), .fwd_i(fwd), .clr_i(clr), .act_o(act),
		.flag_o(flag), .fwd_cnt_o(fwd_cnt));

	// ------------------------------------------------------------
	// Common tasks
	// ------------------------------------------------------------
	function automatic logic [7:0] ad(input int s, input logic [4:0] o);
		return {1'b0, s[1:0], o};
	endfunction : ad

	task automatic results();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results

	task automatic check(input string nm, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick

	task automatic guard(input int n);
		if (n >= 200)
		begin
			error_cnt++;
			results();
		end
	endtask : guard

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		while (!bvalid && n < 200);
		rsp = bresp;
		bready <= 1'b0;
		guard(n);
	endtask : wr

	task automatic rdr(input logic [7:0] a);
		int n;
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
			if (arready) arvalid <= 1'b0;
		end
		while (!rvalid && n < 200);
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
		guard(n);
	endtask : rdr

	task automatic fire_sub(input logic [3:0] m);
		@(posedge clk_i);
		fire <= m;
		@(posedge clk_i);
		fire <= 4'h0;
	endtask : fire_sub

	task automatic wait_q(input int k);
		int n;
		n = 0;
		while (q.size() < k && n < 200)
		begin
			@(posedge clk_i);
			n++;
		end
		guard(n);
	endtask : wait_q

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_gate();
		for (int s = 0; s < 4; s++)
		begin
			wr(ad(s, OFS_CTRL), 32'h04);
			tick(2);
			check("irq ie", irq, 1 << s);
			wr(ad(s, OFS_CTRL), 32'h06);
			tick(2);
			check("irq me", irq, 1 << s);
			rdr(OFS_STATUS);
			check("status", rd[3:0], 1 << s);
			wr(ad(s, OFS_CTRL), 32'h05);
			tick(2);
			check("irq te", irq, 0);
			wr(ad(s, OFS_CTRL), 32'h00);
			tick(2);
			check("irq off", irq, 0);
		end
		rdr(8'h90);
		check("unmapped resp", rsp, RESP_SLVERR);
		check("unmapped data", rd, 0);
		wr(8'h90, 32'h0);
		check("unmapped wr resp", rsp, RESP_SLVERR);
	endtask : t_gate

	task automatic t_full();
		wr(OFS_CONFIG, 32'h03);
		for (int s = 0; s < 4; s++) wr(ad(s, OFS_CTRL), 32'h04);
		tick(2);
		check("full irq", irq, 4'h5);
		for (int s = 0; s < 4; s++) wr(ad(s, OFS_CTRL), 32'h00);
		wr(OFS_CONFIG, 32'h00);
	endtask : t_full

	task automatic t_prio();
		for (int s = 0; s < 4; s++)
		begin
			wr(ad(s, OFS_MAR), 32'hA00010 + 32'(s * 16));
			wr(ad(s, OFS_IO_ADDRESS_REG), 32'h40 + 32'(s));
			wr(ad(s, OFS_CNT), 32'h1);
			wr(ad(s, OFS_CTRL), 32'h05);
		end
		rdr(ad(0, OFS_MAR));
		check("mar", rd[23:0], 24'hA00010);
		q.delete();
		fire_sub(4'hF);
		wait_q(4);
		for (int s = 0; s < 4; s++)
		begin
			check("sub", q[s].sub, s);
			check("mem", q[s].mem_addr,
				(24'hA00010 + 24'(s * 16)) & MAR_1M_MASK);
			check("io", q[s].io_addr, IO_BASE_1M | 24'(8'h40 + s));
		end
		tick(4);
		check("end irq", irq, 4'hF);
		for (int s = 0; s < 4; s++) wr(ad(s, OFS_CTRL), 32'h00);
	endtask : t_prio

	task automatic t_word();
		wr(OFS_CONFIG, 32'h04);
		wr(ad(1, OFS_MAR), 32'hA00010);
		wr(ad(1, OFS_IO_ADDRESS_REG), 32'h42);
		wr(ad(1, OFS_CNT), 32'h2);
		wr(ad(1, OFS_CTRL), 32'h11);
		q.delete();
		fire_sub(4'h2);
		wait_q(1);
		check("w sub", q[0].sub, 1);
		check("w word", q[0].word, 1);
		check("w mem", q[0].mem_addr, 24'hA00010);
		check("w io", q[0].io_addr, IO_BASE_16M | 24'h42);
		tick(2);
		rdr(ad(1, OFS_MAR));
		check("w step", rd[23:0], 24'hA00010 + STEP_WORD);
		wr(ad(1, OFS_CTRL), 32'h00);
		wr(OFS_CONFIG, 32'h00);
	endtask : t_word

	task automatic t_nmi();
		wr(OFS_CONFIG, 32'h01);
		wr(ad(0, OFS_CNT), 32'h10);
		wr(ad(0, OFS_BLK_INIT), 32'h08);
		wr(ad(0, OFS_CTRL), 32'h0B);
		q.delete();
		fire_sub(4'h1);
		wait_q(1);
		nmi_i <= 1'b1;
		@(posedge clk_i);
		nmi_i <= 1'b0;
		tick(6);
		check("flag", flag[0], 0);
		rdr(ad(0, OFS_CTRL));
		check("halt", rd[1:0], 2'b01);
		rdr(ad(0, OFS_BLK_CNT));
		check("mid block", rd[7:0] != 8'h08, 1);
		q.delete();
		cnt0 = fwd_cnt;
		fire_sub(4'h1);
		tick(8);
		check("ignored", q.size(), 0);
		check("no cpu irq", fwd_cnt, cnt0);
		wr(ad(0, OFS_CTRL), 32'h0A);
		fire_sub(4'h1);
		tick(3);
		check("cpu irq", fwd_cnt, cnt0 + 8'h01);
		wr(ad(0, OFS_CTRL), 32'h0B);
		q.delete();
		fire_sub(4'h1);
		wait_q(1);
		check("resume", q[0].sub, 0);
	endtask : t_nmi

	task automatic t_standby();
		wr(ad(2, OFS_CTRL), 32'h04);
		tick(2);
		check("pre", irq[2], 1);
		standby_i <= 1'b1;
		@(posedge clk_i);
		standby_i <= 1'b0;
		tick(2);
		check("stby irq", irq, 0);
		rdr(ad(2, OFS_CTRL));
		check("stby ctrl", rd, 0);
	endtask : t_standby

	initial
	begin
		repeat (6) @(posedge clk_i);
		rst_b_i <= 1'b1;
		tick(2);
		t_gate();
		t_full();
		t_prio();
		t_word();
		t_nmi();
		t_standby();
		results();
	end
endmodule : dma_end_irq_and_halt_control_test

`default_nettype wire
